// File: usc_pkg.sv
// package: register map, field positions, timing counts and carriers of the status/control block
package usc_pkg;
	localparam logic [7:0] IDX_TX_NINTH = 8'h03;
	localparam logic [7:0] IDX_FLAGS    = 8'h04;
	localparam logic [7:0] IDX_CTRL_A   = 8'h05;
	localparam logic [7:0] IDX_CTRL_B   = 8'h06;
	localparam logic [7:0] RST_CTRL     = 8'h00;
	// status bit positions
	localparam int B_RXC = 7;
	localparam int B_TXC = 6;
	localparam int B_DRE = 5;
	localparam int B_RXS = 4;
	localparam int B_ISF = 3;
	localparam int B_BDF = 1;
	localparam int B_WFB = 0;
	// receiver speed modes
	localparam logic [1:0] RM_NORMAL = 2'h0;
	localparam logic [1:0] RM_DOUBLE = 2'h1;
	localparam logic [1:0] RM_GENERIC = 2'h2;
	localparam logic [1:0] RM_LIN     = 2'h3;
	// line driver modes
	localparam logic [1:0] LD_OFF = 2'h0;
	localparam logic [1:0] LD_EXT = 2'h1;
	localparam logic [1:0] LD_INT = 2'h2;
	// timing counts
	localparam logic [3:0] BREAK_BITS    = 4'hb;
	localparam logic [7:0] SYNC_PAIR_NOM = 8'h20;
	localparam logic [7:0] SYNC_PAIR_TOL = 8'h06;
	localparam logic [7:0] SYNC_BYTE     = 8'h55;
	localparam logic [4:0] DIV_NORMAL    = 5'h10;
	localparam logic [4:0] DIV_DOUBLE    = 5'h08;

	typedef enum logic [1:0] {
		AB_IDLE  = 2'b00,
		AB_BREAK = 2'b01,
		AB_SYNC  = 2'b11
	} usc_ab_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} usc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} usc_apb_rsp_t;

	// pulses and levels from the neighbouring shifter, buffer and baud logic
	typedef struct packed {
		logic       rx_buf_nonempty;
		logic       rx_data_received;
		logic       tx_low_write;
		logic       tx_buf_taken;
		logic       tx_shift_busy;
		logic       tx_frame_done;
		logic       txc_vector_ack;
		logic       bit_tick;
		logic       sync_pair_pulse;
		logic [7:0] sync_pair_samples;
		logic       sync_done;
		logic [7:0] sync_byte;
		logic       sync_rate_ok;
		logic       sync_mode;
		logic       spi_master;
		logic       standby;
		logic       sleeping;
	} usc_events_t;

	typedef struct packed {
		logic       rx_line;
		logic       rx_flush;
		logic       autobaud_reset;
		logic       autobaud_abort;
		logic       tx_active;
		logic       transmit_ninth_bit;
		logic [4:0] baud_divisor;
		logic       multiprocessor_filter_en;
		logic       irq_rxc;
		logic       irq_txc;
		logic       irq_dre;
		logic       wake;
	} usc_ctrl_t;
endpackage

// File: usc_regs.sv
// status, interrupt enable and line control registers of the serial port, apb slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module usc_regs (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  clk_en,
	input  wire usc_pkg::usc_apb_req_t apb_req,
	output usc_pkg::usc_apb_rsp_t      apb_rsp,
	input  wire usc_pkg::usc_events_t  ev,
	output usc_pkg::usc_ctrl_t         ctrl,
	input  wire logic                  rxd_pin,
	input  wire logic                  tx_serial,
	output logic                       txd_o,
	output logic                       txd_oe,
	output logic                       transmit_enable_pin
);
	import usc_pkg::*;

	logic [7:0]    ctrl_a_q;
	logic [7:0]    ctrl_b_q;
	logic          ninth_q;
	logic          txc_q;
	logic          dre_q;
	logic          rxs_q;
	logic          isf_q;
	logic          bdf_q;
	logic          wfb_q;
	logic          rx_meta_q;
	logic          rx_sync_q;
	logic          rx_prev_q;
	logic          receiver_en_prev_q;
	logic          tx_active_q;
	logic          ack_q;
	logic [3:0]    low_bits_q;
	logic          wfb_low_q;
	usc_ab_state_t ab_q;
	logic [31:0]   rdata_q;

	logic       rx_line;
	logic       fall;
	logic       rise;
	logic       access;
	logic       wr_en;
	logic       mapped;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic       wr_flags;
	logic       tx_pending;
	logic       rx_complete;
	logic       autobaud;
	logic       rx_flush;
	logic       pair_bad;
	logic       sync_err;
	logic       isf_clear;
	logic       tx_bit;

	// field aliases
	logic       receiver_en;
	logic       transmitter_en;
	logic       start_frame_detect_en;
	logic       open_drain_en;
	logic [1:0] receiver_speed_mode;
	logic [1:0] ldmode;

	assign receiver_en   = ctrl_b_q[7];
	assign transmitter_en   = ctrl_b_q[6];
	assign start_frame_detect_en  = ctrl_b_q[4];
	assign open_drain_en   = ctrl_b_q[3];
	assign receiver_speed_mode = ctrl_b_q[2:1];
	assign ldmode = ctrl_a_q[1:0];

	// apb decode: printed offsets are word indices, byte address is four times them
	assign idx    = {2'b00, apb_req.paddr[7:2]};
	assign access = apb_req.psel && apb_req.penable;
	assign wbyte  = apb_req.pwdata[7:0];
	always_comb begin
		if (apb_req.paddr[1:0] != 2'b00) begin
			mapped = 1'b0;
		end else if (idx == IDX_TX_NINTH || idx == IDX_FLAGS) begin
			mapped = 1'b1;
		end else if (idx == IDX_CTRL_A || idx == IDX_CTRL_B) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	// one wait state so read data leaves a flip-flop
	assign apb_rsp.pready  = access && ack_q && clk_en;
	assign apb_rsp.pslverr = access && ack_q && clk_en && !mapped;
	assign apb_rsp.prdata  = rdata_q;
	assign wr_en    = apb_rsp.pready && apb_req.pwrite && mapped;
	assign wr_flags = wr_en && idx == IDX_FLAGS;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= 1'b0;
		end else if (clk_en) begin
			ack_q <= access && !ack_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			if (access && !ack_q && !apb_req.pwrite) begin
				if (idx == IDX_FLAGS) begin
					// wait-for-break always reads zero
					rdata_q <= {24'h00_0000, rx_complete, txc_q, dre_q, rxs_q && start_frame_detect_en,
						isf_q, 1'b0, bdf_q, 1'b0};
				end else if (idx == IDX_CTRL_A) begin
					rdata_q <= {24'h00_0000, ctrl_a_q};
				end else if (idx == IDX_CTRL_B) begin
					rdata_q <= {24'h00_0000, ctrl_b_q};
				end else begin
					rdata_q <= 32'h0000_0000;
				end
			end
		end
	end

	// control registers; bit 5 of the second one is unimplemented
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_q <= RST_CTRL;
			ctrl_b_q <= RST_CTRL;
			ninth_q  <= 1'b0;
		end else if (clk_en && wr_en) begin
			if (idx == IDX_CTRL_A) begin
				ctrl_a_q <= wbyte;
			end else if (idx == IDX_CTRL_B) begin
				ctrl_b_q <= wbyte & 8'hdf;
			end else if (idx == IDX_TX_NINTH) begin
				// write ordering against the low byte is the software's duty
				ninth_q <= wbyte[0];
			end
		end
	end

	// receive line synchroniser; loop-back taps the transmit bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else if (clk_en) begin
			rx_meta_q <= rxd_pin;
			rx_sync_q <= rx_meta_q;
			rx_prev_q <= rx_line;
		end
	end
	assign rx_line = ctrl_a_q[3] ? tx_bit : rx_sync_q;
	assign fall    = rx_prev_q && !rx_line;
	assign rise    = !rx_prev_q && rx_line;

	// receiver side
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receiver_en_prev_q <= 1'b0;
		end else if (clk_en) begin
			receiver_en_prev_q <= receiver_en;
		end
	end
	assign rx_flush    = receiver_en_prev_q && !receiver_en;
	assign rx_complete = receiver_en && ev.rx_buf_nonempty;
	assign autobaud    = receiver_speed_mode == RM_GENERIC || receiver_speed_mode == RM_LIN;

	// transmitter side
	assign tx_pending = ev.tx_shift_busy || !dre_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dre_q <= 1'b1;
		end else if (clk_en) begin
			if (ev.tx_buf_taken) begin
				dre_q <= 1'b1;
			end else if (ev.tx_low_write) begin
				dre_q <= 1'b0;
			end
		end
	end

	// set beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txc_q <= 1'b0;
		end else if (clk_en) begin
			if (ev.tx_frame_done && dre_q && !ev.tx_low_write) begin
				txc_q <= 1'b1;
			end else if (ev.txc_vector_ack || (wr_flags && wbyte[B_TXC])) begin
				txc_q <= 1'b0;
			end
		end
	end

	// disable only lands once shifter and buffer are empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_active_q <= 1'b0;
		end else if (clk_en) begin
			tx_active_q <= transmitter_en || (tx_active_q && tx_pending);
		end
	end

	// pin drive: released pin is an input; open drain only pulls low
	assign tx_bit = tx_active_q ? tx_serial : 1'b1;
	always_comb begin
		txd_o  = 1'b0;
		txd_oe = 1'b0;
		if (tx_active_q) begin
			if (open_drain_en) begin
				txd_oe = !tx_serial;
			end else begin
				txd_o  = tx_serial;
				txd_oe = 1'b1;
			end
			if (ldmode == LD_INT && !tx_pending) begin
				txd_oe = 1'b0;
			end
		end
	end
	assign transmit_enable_pin = ldmode == LD_EXT && tx_active_q && tx_pending;

	// start detect: standby only, idle when start detection is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxs_q <= 1'b0;
		end else if (clk_en) begin
			if (start_frame_detect_en && ev.standby && fall && !ev.spi_master) begin
				rxs_q <= 1'b1;
			end else if (!start_frame_detect_en || (wr_flags && wbyte[B_RXS])) begin
				rxs_q <= 1'b0;
			end
		end
	end

	// auto-baud: break measurement then sync check
	assign pair_bad = ev.sync_pair_samples < SYNC_PAIR_NOM - SYNC_PAIR_TOL
		|| ev.sync_pair_samples > SYNC_PAIR_NOM + SYNC_PAIR_TOL;
	assign isf_clear = wr_flags && wbyte[B_ISF];
	always_comb begin
		sync_err = 1'b0;
		if (ab_q == AB_SYNC) begin
			if (receiver_speed_mode == RM_LIN && ev.sync_pair_pulse && pair_bad) begin
				sync_err = 1'b1;
			end else if (ev.sync_done && !ev.sync_rate_ok) begin
				sync_err = 1'b1;
			end else if (ev.sync_done && receiver_speed_mode == RM_LIN && ev.sync_byte != SYNC_BYTE) begin
				sync_err = 1'b1;
			end
		end
	end

	// detection is only meaningful for an asynchronous slave
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ab_q       <= AB_IDLE;
			low_bits_q <= 4'h0;
		end else if (clk_en) begin
			if (!autobaud || !receiver_en || ev.sync_mode || isf_clear) begin
				ab_q       <= AB_IDLE;
				low_bits_q <= 4'h0;
			end else begin
				case (ab_q)
					AB_IDLE: begin
						low_bits_q <= 4'h0;
						if (fall) begin
							ab_q <= AB_BREAK;
						end
					end
					AB_BREAK: begin
						if (rise) begin
							if (low_bits_q >= BREAK_BITS || wfb_low_q) begin
								ab_q <= AB_SYNC;
							end else begin
								ab_q <= AB_IDLE;
							end
						end else if (ev.bit_tick && low_bits_q != 4'hf) begin
							low_bits_q <= low_bits_q + 4'h1;
						end
					end
					AB_SYNC: begin
						if (ev.sync_done || sync_err) begin
							ab_q <= AB_IDLE;
						end
					end
					default: begin
						ab_q <= AB_IDLE;
					end
				endcase
			end
		end
	end

	// wait-for-break arms, then latches the low phase of the next transition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wfb_q     <= 1'b0;
			wfb_low_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_flags && wbyte[B_WFB]) begin
				wfb_q <= 1'b1;
			end else if (wfb_q && fall) begin
				wfb_q <= 1'b0;
			end
			if (wfb_q && fall) begin
				wfb_low_q <= 1'b1;
			end else if (ab_q != AB_BREAK) begin
				wfb_low_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			isf_q <= 1'b0;
		end else if (clk_en) begin
			if (sync_err) begin
				isf_q <= 1'b1;
			end else if (isf_clear) begin
				isf_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bdf_q <= 1'b0;
		end else if (clk_en) begin
			if (ab_q == AB_SYNC && ev.sync_done && !sync_err) begin
				bdf_q <= 1'b1;
			end else if (!autobaud || ev.rx_data_received || (wr_flags && wbyte[B_BDF])) begin
				bdf_q <= 1'b0;
			end
		end
	end

	// outputs to the neighbouring logic
	assign ctrl.rx_line            = rx_line;
	assign ctrl.rx_flush           = rx_flush;
	assign ctrl.autobaud_reset     = rx_flush && autobaud;
	assign ctrl.autobaud_abort     = isf_clear;
	assign ctrl.tx_active          = tx_active_q;
	assign ctrl.transmit_ninth_bit = ninth_q;
	// doubling has no meaning for a synchronous link
	assign ctrl.baud_divisor = (receiver_speed_mode == RM_DOUBLE && !ev.sync_mode)
		? DIV_DOUBLE : DIV_NORMAL;
	assign ctrl.multiprocessor_filter_en = ctrl_b_q[0];
	assign ctrl.irq_rxc = (ctrl_a_q[7] && rx_complete) || (ctrl_a_q[4] && rxs_q && start_frame_detect_en)
		|| (ctrl_a_q[2] && isf_q);
	assign ctrl.irq_txc = ctrl_a_q[6] && txc_q;
	assign ctrl.irq_dre = ctrl_a_q[5] && dre_q;
	assign ctrl.wake    = start_frame_detect_en && (ev.standby || ev.sleeping) && fall;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_rx_flag_follows: assert property (ctrl.irq_rxc && !ctrl_a_q[4] && !ctrl_a_q[2] |-> receiver_en
		&& ev.rx_buf_nonempty) else $error("receive vector without unread data");
	a_txc_set: assert property (clk_en && ev.tx_frame_done && dre_q && !ev.tx_low_write
		|=> txc_q) else $error("transmit-complete did not set");
	a_dre_clear: assert property (clk_en && ev.tx_low_write && !ev.tx_buf_taken
		|=> !dre_q) else $error("buffer-empty not cleared by low-byte write");
	a_start_w1c: assert property (clk_en && rxs_q && start_frame_detect_en && !(wr_flags && wbyte[B_RXS])
		|=> rxs_q) else $error("start flag cleared without a written one");
	a_sync_bad_byte: assert property (clk_en && ab_q == AB_SYNC && receiver_speed_mode == RM_LIN
		&& ev.sync_done && ev.sync_byte != SYNC_BYTE && autobaud && receiver_en && !ev.sync_mode
		&& !isf_clear |=> isf_q && ab_q == AB_IDLE) else $error("bad sync byte not flagged");
	a_short_break: assert property (clk_en && ab_q == AB_BREAK && rise
		&& low_bits_q < BREAK_BITS && !wfb_low_q && autobaud && receiver_en && !ev.sync_mode && !isf_clear
		|=> ab_q == AB_IDLE) else $error("short low accepted as break");
	a_tx_hold: assert property (clk_en && tx_active_q && !transmitter_en && tx_pending
		|=> tx_active_q) else $error("transmitter released with data pending");
	a_open_drain: assert property (tx_active_q && open_drain_en |-> !(txd_oe && txd_o))
		else $error("open-drain pin driven high");
	a_loopback: assert property (ctrl_a_q[3] && tx_active_q |-> rx_line == tx_serial)
		else $error("loop-back path broken");
	a_apb_wait: assert property (access && !ack_q |-> !apb_rsp.pready)
		else $error("apb answered without wait state");

	c_break_sync: cover property (ab_q == AB_BREAK ##[1:1000] ab_q == AB_SYNC ##[1:1000] bdf_q);
	c_txc_irq: cover property (ctrl.irq_txc ##1 !txc_q);
	c_tx_drain: cover property (tx_active_q && !transmitter_en ##[1:500] !tx_active_q);
	c_sync_error: cover property (isf_q && ctrl.irq_rxc);
endmodule

// File: usc_remote_node.sv
// remote serial node: drives the receive line and sees the transmit wire
`timescale 1ns/1ps
module usc_remote_node (
	input  wire logic pclk,
	input  wire logic txd_o,
	input  wire logic txd_oe,
	output logic      rxd,
	output logic      tx_wire
);
	// pull-up on the wire, so a released pin reads one
	assign tx_wire = txd_oe ? txd_o : 1'b1;
	initial rxd = 1'b1;
	// idle line is high; level changes only right after a clock edge
	task automatic set_line(input logic v);
		@(posedge pclk);
		rxd <= v;
	endtask
endmodule

// File: test_uart_status_control_regs.sv
// testbench of the status and control registers, scenario per task
`timescale 1ns/1ps
module test_uart_status_control_regs;
	import usc_pkg::*;
	localparam logic [7:0] A_NI = IDX_TX_NINTH << 2;
	localparam logic [7:0] A_FL = IDX_FLAGS << 2;
	localparam logic [7:0] A_CA = IDX_CTRL_A << 2;
	localparam logic [7:0] A_CB = IDX_CTRL_B << 2;
	logic         pclk = 1'b0;
	logic         presetn = 1'b0;
	logic         clk_en = 1'b1;
	logic         tx_serial = 1'b1;
	usc_apb_req_t req = '0;
	usc_apb_rsp_t rsp;
	usc_events_t  ev = '0;
	usc_events_t  lv = '0;
	usc_ctrl_t    ctrl;
	logic         txd_o, txd_oe, te_pin, rxd, tx_wire, err;
	logic         woke = 1'b0;
	logic         flushed = 1'b0;
	logic         aborted = 1'b0;
	logic         ab_reset_seen = 1'b0;
	logic [31:0]  r;
	int           fails = 0;
	int           n_checks = 0;

	usc_regs usc_regs_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req),
		.apb_rsp(rsp), .ev(ev), .ctrl(ctrl), .rxd_pin(rxd), .tx_serial(tx_serial),
		.txd_o(txd_o), .txd_oe(txd_oe), .transmit_enable_pin(te_pin));
	usc_remote_node usc_remote_node_i (.pclk(pclk), .txd_o(txd_o), .txd_oe(txd_oe),
		.rxd(rxd), .tx_wire(tx_wire));

	always #12.5 pclk = ~pclk;
	// pulses are one cycle wide, so latch them for later comparison
	always @(posedge pclk) begin
		if (ctrl.wake === 1'b1) woke <= 1'b1;
		if (ctrl.rx_flush === 1'b1) flushed <= 1'b1;
		if (ctrl.autobaud_abort === 1'b1) aborted <= 1'b1;
		if (ctrl.autobaud_reset === 1'b1) ab_reset_seen <= 1'b1;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		// read in the edge's own time step, values are those the design samples there
		@(posedge pclk);
		while (rsp.pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				give_verdict();
			end
			@(posedge pclk);
		end
		r = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic lvl(input usc_events_t v);
		lv = v;
		@(posedge pclk);
		ev <= v;
	endtask
	task automatic pulse(input usc_events_t p);
		@(posedge pclk);
		ev <= lv | p;
		@(posedge pclk);
		ev <= lv;
	endtask
	task automatic brk(input int ticks);
		usc_remote_node_i.set_line(1'b0);
		repeat (4) @(posedge pclk);
		repeat (ticks) pulse('{bit_tick: 1'b1, default: '0});
		usc_remote_node_i.set_line(1'b1);
		repeat (4) @(posedge pclk);
	endtask
	task automatic syncd(input logic [7:0] b, input logic ok);
		pulse('{sync_done: 1'b1, sync_byte: b, sync_rate_ok: ok, default: '0});
		rd(A_FL);
	endtask

	task automatic t_reset();
		rd(A_FL);
		chk(r, 32'h20, "flags after reset");
		rd(A_CA);
		chk(r, 32'h0, "ctrl a reset");
		rd(A_CB);
		chk(r, 32'h0, "ctrl b reset");
		rd(8'h1c);
		chk(err, 1'b1, "unmapped address");
		rd(8'h11);
		chk(err, 1'b1, "unaligned address");
		chk(ctrl.baud_divisor, DIV_NORMAL, "divisor after reset");
	endtask
	task automatic t_tx();
		wr(A_NI, 32'h1);
		settle(0);
		chk(ctrl.transmit_ninth_bit, 1'b1, "ninth bit");
		rd(A_NI);
		chk(r, 32'h0, "ninth bit reads zero");
		pulse('{tx_low_write: 1'b1, default: '0});
		pulse('{tx_frame_done: 1'b1, default: '0});
		rd(A_FL);
		chk(r, 32'h0, "buffer full, no tx complete");
		pulse('{tx_buf_taken: 1'b1, default: '0});
		rd(A_FL);
		chk(r, 32'h20, "buffer empty again");
		pulse('{tx_frame_done: 1'b1, default: '0});
		rd(A_FL);
		chk(r, 32'h60, "tx complete set");
		wr(A_FL, 32'h0);
		rd(A_FL);
		chk(r, 32'h60, "zero write keeps flags");
		wr(A_FL, 32'h40);
		rd(A_FL);
		chk(r, 32'h20, "one clears tx complete");
		pulse('{tx_frame_done: 1'b1, default: '0});
		pulse('{txc_vector_ack: 1'b1, default: '0});
		rd(A_FL);
		chk(r, 32'h20, "vector clears tx complete");
	endtask
	task automatic t_irq();
		wr(A_CA, 32'he0);
		pulse('{tx_frame_done: 1'b1, default: '0});
		settle(1);
		chk({ctrl.irq_rxc, ctrl.irq_txc, ctrl.irq_dre}, 3'b011, "tx irqs");
		wr(A_CB, 32'h80);
		lvl('{rx_buf_nonempty: 1'b1, default: '0});
		settle(1);
		chk({ctrl.irq_rxc, ctrl.irq_txc, ctrl.irq_dre}, 3'b111, "all irqs");
		rd(A_FL);
		chk(r, 32'he0, "rx complete");
		flushed = 1'b0;
		wr(A_CB, 32'h0);
		rd(A_FL);
		chk(r, 32'h60, "disable clears rx complete");
		chk(flushed, 1'b1, "receive flush");
		wr(A_CA, 32'h0);
		settle(0);
		chk({ctrl.irq_rxc, ctrl.irq_txc, ctrl.irq_dre}, 3'b000, "irqs masked");
		lvl('0);
		wr(A_FL, 32'h40);
	endtask
	task automatic t_line();
		// loop-back taps the transmit bit, so the transmitter must own the pin
		wr(A_CB, 32'h40);
		wr(A_CA, 32'h02);
		settle(0);
		chk(txd_oe, 1'b0, "internal driver off when idle");
		wr(A_CA, 32'h08);
		tx_serial <= 1'b0;
		settle(3);
		chk(ctrl.rx_line, 1'b0, "loop-back");
		tx_serial <= 1'b1;
		wr(A_CA, 32'h0);
		usc_remote_node_i.set_line(1'b0);
		settle(3);
		chk(ctrl.rx_line, 1'b0, "pin to receiver");
		usc_remote_node_i.set_line(1'b1);
		wr(A_CB, 32'h48);
		settle(0);
		chk(tx_wire, 1'b1, "open drain floats one");
		chk(txd_oe, 1'b0, "open drain released");
		tx_serial <= 1'b0;
		settle(1);
		chk(tx_wire, 1'b0, "open drain drives low");
		tx_serial <= 1'b1;
		lvl('{tx_shift_busy: 1'b1, default: '0});
		wr(A_CB, 32'h40);
		wr(A_CA, 32'h01);
		settle(0);
		chk(te_pin, 1'b1, "external driver enable");
		wr(A_CA, 32'h03);
		settle(0);
		chk(te_pin, 1'b0, "reserved mode off");
		wr(A_CA, 32'h02);
		settle(0);
		chk({te_pin, txd_oe}, 2'b01, "internal driver on while pending");
		wr(A_CB, 32'h0);
		settle(1);
		chk({ctrl.tx_active, txd_oe}, 2'b11, "disable waits for shifter");
		lvl('0);
		settle(2);
		chk({ctrl.tx_active, txd_oe}, 2'b00, "pin released");
		wr(A_CA, 32'h0);
		wr(A_CB, 32'h03);
		settle(0);
		chk(ctrl.baud_divisor, DIV_DOUBLE, "double speed");
		chk(ctrl.multiprocessor_filter_en, 1'b1, "address filter");
		wr(A_CB, 32'h01);
		lvl('{sync_mode: 1'b1, default: '0});
		settle(0);
		chk(ctrl.baud_divisor, DIV_NORMAL, "synchronous link keeps mode zero");
		lvl('0);
		wr(A_CB, 32'hff);
		rd(A_CB);
		chk(r, 32'hdf, "ctrl b unused bit");
		wr(A_CB, 32'h0);
	endtask
	task automatic t_start();
		lvl('{standby: 1'b1, default: '0});
		wr(A_CB, 32'h10);
		wr(A_CA, 32'h10);
		woke = 1'b0;
		usc_remote_node_i.set_line(1'b0);
		settle(5);
		chk(woke, 1'b1, "wake on start");
		chk(ctrl.irq_rxc, 1'b1, "start irq");
		rd(A_FL);
		chk(r[4], 1'b1, "start flag");
		usc_remote_node_i.set_line(1'b1);
		wr(A_FL, 32'h0);
		rd(A_FL);
		chk(r[4], 1'b1, "start flag kept");
		wr(A_FL, 32'h10);
		rd(A_FL);
		chk(r[4], 1'b0, "start flag cleared");
		usc_remote_node_i.set_line(1'b0);
		settle(5);
		wr(A_CB, 32'h0);
		rd(A_FL);
		chk(r[4], 1'b0, "start flag off without detect");
		usc_remote_node_i.set_line(1'b1);
		lvl('0);
		wr(A_CA, 32'h0);
		lvl('{standby: 1'b1, spi_master: 1'b1, default: '0});
		wr(A_CB, 32'h10);
		usc_remote_node_i.set_line(1'b0);
		settle(5);
		rd(A_FL);
		chk(r[4], 1'b0, "no start flag as spi master");
		usc_remote_node_i.set_line(1'b1);
		lvl('{sleeping: 1'b1, default: '0});
		woke = 1'b0;
		usc_remote_node_i.set_line(1'b0);
		settle(5);
		chk(woke, 1'b1, "wake from idle sleep");
		usc_remote_node_i.set_line(1'b1);
		lvl('0);
		wr(A_CB, 32'h0);
	endtask
	task automatic t_autobaud();
		wr(A_CB, 32'h86);
		wr(A_CA, 32'h04);
		brk(11);
		syncd(8'h54, 1'b1);
		chk(r[3], 1'b1, "sync byte error");
		chk(ctrl.irq_rxc, 1'b1, "sync error irq");
		wr(A_FL, 32'h08);
		rd(A_FL);
		chk(r[3], 1'b0, "sync error cleared");
		brk(11);
		syncd(8'h55, 1'b1);
		chk(r[3:1], 3'b001, "break after sync");
		pulse('{rx_data_received: 1'b1, default: '0});
		rd(A_FL);
		chk(r[1], 1'b0, "break cleared by data");
		brk(10);
		syncd(8'h55, 1'b1);
		chk(r[1], 1'b0, "short low is no break");
		wr(A_CB, 32'h84);
		brk(11);
		syncd(8'h12, 1'b1);
		chk(r[3:1], 3'b001, "generic accepts any byte");
		wr(A_FL, 32'h02);
		brk(11);
		syncd(8'h55, 1'b0);
		chk(r[3:1], 3'b100, "bad rate");
		wr(A_FL, 32'h08);
		wr(A_FL, 32'h01);
		rd(A_FL);
		chk(r[0], 1'b0, "wait-for-break reads zero");
		brk(2);
		syncd(8'h55, 1'b1);
		chk(r[1], 1'b1, "armed break of any width");
		wr(A_FL, 32'h02);
		wr(A_CB, 32'h86);
		brk(11);
		pulse('{sync_pair_pulse: 1'b1, sync_pair_samples: 8'h19, default: '0});
		rd(A_FL);
		chk(r[3], 1'b1, "sync pair too short");
		aborted = 1'b0;
		wr(A_FL, 32'h08);
		settle(0);
		chk(aborted, 1'b1, "written one returns to idle");
		brk(11);
		pulse('{sync_pair_pulse: 1'b1, sync_pair_samples: 8'h26, default: '0});
		syncd(8'h55, 1'b1);
		chk(r[3:1], 3'b001, "sync pair at upper limit");
		ab_reset_seen = 1'b0;
		wr(A_CB, 32'h06);
		settle(1);
		chk(ab_reset_seen, 1'b1, "receiver off resets baud detection");
		wr(A_CB, 32'h0);
		wr(A_CA, 32'h0);
	endtask
	task automatic t_freeze();
		@(posedge pclk);
		clk_en <= 1'b0;
		pulse('{tx_low_write: 1'b1, default: '0});
		@(posedge pclk);
		clk_en <= 1'b1;
		rd(A_FL);
		chk(r[5], 1'b1, "state frozen while clock enable low");
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		fails++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_tx();
		t_irq();
		t_line();
		t_start();
		t_autobaud();
		t_freeze();
		give_verdict();
	end
endmodule
